// ### main_osc_model.sv
`timescale 1ns/1ps
module main_osc_model (
  // Clock and control
  input wire i_core_clk,
  input wire i_en,
  input wire i_dead,
  // Resonator output
  output reg o_osc
);
  initial o_osc = 1'b0;
  // Stands still when disabled or disconnected
  always @(posedge i_core_clk) begin
    if (i_en && !i_dead) o_osc <= ~o_osc;
  end
endmodule // main_osc_model

// ### osc_lp_ctrl.v
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "osc_lp_map.vh"

module osc_lp_ctrl (
  // Clock and external reset
  input wire i_core_clk,
  input wire i_rstn,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Bit operation marker for writes
  input wire i_bit_op,
  input wire [2:0] i_bit_idx,
  // CPU events
  input wire i_stop_instruction,
  input wire i_wait_instruction,
  input wire i_ext_irq_accept,
  input wire i_irq_accept,
  // Oscillator pins
  input wire i_main_osc_input,
  output wire o_main_osc_en,
  output wire o_onchip_osc_en,
  // Clock outputs
  output reg o_phi_en,
  output wire o_phi_held,
  output wire o_on_chip_active,
  // Internal reset
  output reg o_osc_stop_reset
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_STOP = 2'd2;
  localparam [1:0] ST_STAB = 2'd3;

  reg [1:0] state_q;
  reg [7:0] cpumode_q;
  reg [7:0] tcsrc_q;
  reg [1:0] osdctl_q;
  reg status_q;
  reg lock_q;
  reg onchip_sel_q;
  reg [7:0] presc_q;
  reg [7:0] presc_rld_q;
  reg [7:0] timer_q;
  reg [7:0] timer_rld_q;
  reg [3:0] onchip_cnt_q;
  reg [3:0] main_pre_q;
  reg [2:0] phi_div_q;
  reg [3:0] loss_cnt_q;
  reg main_in_q;
  reg main_prev_q;

  wire rst_all;
  wire main_run;
  wire onchip_run;
  wire onchip_tick;
  wire main_edge;
  wire main_pre_tick;
  wire src_tick;
  wire presc_tick;
  wire presc_uf;
  wire timer_uf;
  wire clk_tick;
  wire [2:0] div_max;
  wire wr_cm;
  wire bit_op_lock;
  wire [7:0] lock_hit;
  wire detect_on;
  wire loss;

  // Oscillator-stop reset re-initialises everything but the status flag
  assign rst_all = !i_rstn || o_osc_stop_reset; // RULE18

  // ----------------------------------------
  // Oscillator sources
  // ----------------------------------------
  assign main_run = !cpumode_q[`CM_MAIN_RUN] && (state_q != ST_STOP); // RULE1 RULE15
  assign onchip_run = !cpumode_q[`CM_ONCHIP_RUN]; // RULE15
  assign o_main_osc_en = main_run;
  assign o_onchip_osc_en = onchip_run;
  assign o_on_chip_active = onchip_sel_q;

  assign onchip_tick = onchip_run && (onchip_cnt_q == `ONCHIP_DIV);
  assign main_edge = main_run && main_in_q && !main_prev_q;
  assign main_pre_tick = main_edge && (main_pre_q == `MAIN_PRE_DIV);

  always @(posedge i_core_clk) begin
    if (rst_all) begin
      onchip_cnt_q <= 4'h0;
      main_pre_q <= 4'h0;
      main_in_q <= 1'b0;
      main_prev_q <= 1'b0;
    end else begin
      main_in_q <= i_main_osc_input;
      main_prev_q <= main_in_q;
      if (!onchip_run || onchip_tick) begin
        onchip_cnt_q <= 4'h0;
      end else begin
        onchip_cnt_q <= onchip_cnt_q + 4'h1;
      end
      if (main_edge) begin
        main_pre_q <= main_pre_tick ? 4'h0 : main_pre_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Prescaler 1 and timer 1
  // ----------------------------------------
  assign src_tick = tcsrc_q[`TC_T1_SRC] ? onchip_tick : main_pre_tick; // RULE4
  assign presc_tick = src_tick;
  assign presc_uf = presc_tick && (presc_q == 8'h00);
  assign timer_uf = presc_uf && (timer_q == 8'h00); // RULE23

  always @(posedge i_core_clk) begin
    if (rst_all) begin
      presc_q <= `RST_PRESC1;
      presc_rld_q <= `RST_PRESC1;
      timer_q <= `RST_TIMER1;
      timer_rld_q <= `RST_TIMER1;
    end else if (i_stop_instruction && state_q == ST_RUN) begin
      if (!osdctl_q[`OSD_STAB_SEL]) begin // RULE3
        presc_q <= `STOP_PRESC1; // RULE2
        presc_rld_q <= `STOP_PRESC1; // RULE2
        timer_q <= `STOP_TIMER1; // RULE2
        timer_rld_q <= `STOP_TIMER1; // RULE2
      end
    end else begin
      if (i_wr && i_addr == `ADDR_PRESC1) begin
        presc_q <= i_wdata;
        presc_rld_q <= i_wdata;
      end else if (presc_uf) begin
        presc_q <= presc_rld_q;
      end else if (presc_tick) begin
        presc_q <= presc_q - 8'h01;
      end
      if (i_wr && i_addr == `ADDR_TIMER1) begin
        timer_q <= i_wdata;
        timer_rld_q <= i_wdata;
      end else if (timer_uf) begin
        timer_q <= timer_rld_q;
      end else if (presc_uf) begin
        timer_q <= timer_q - 8'h01; // RULE23
      end
    end
  end

  // ----------------------------------------
  // Low-power state machine
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (rst_all) begin
      state_q <= ST_RUN; // RULE6 RULE9
    end else begin
      case (state_q)
        ST_RUN: begin
          if (i_stop_instruction) begin
            state_q <= ST_STOP; // RULE1
          end else if (i_wait_instruction) begin
            state_q <= ST_WAIT; // RULE8
          end
        end
        ST_WAIT: begin
          if (i_irq_accept || i_ext_irq_accept) begin
            state_q <= ST_RUN; // RULE9
          end
        end
        ST_STOP: begin
          if (i_ext_irq_accept) begin
            state_q <= ST_STAB; // RULE5
          end
        end
        ST_STAB: begin
          if (timer_uf) begin
            state_q <= ST_RUN; // RULE5 RULE23
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  assign o_phi_held = (state_q != ST_RUN); // RULE1 RULE5 RULE8

  // ----------------------------------------
  // Internal clock division
  // ----------------------------------------
  assign clk_tick = onchip_sel_q ? onchip_tick : main_edge; // RULE11
  assign div_max = (cpumode_q[`CM_RATIO_HI:`CM_RATIO_LO] == `RATIO_DOUBLE) ? 3'd0 :
                   (cpumode_q[`CM_RATIO_HI:`CM_RATIO_LO] == `RATIO_HIGH) ? `DIV_HIGH :
                   `DIV_MIDDLE; // RULE16

  always @(posedge i_core_clk) begin
    if (rst_all) begin
      phi_div_q <= 3'd0;
      o_phi_en <= 1'b0;
    end else begin
      o_phi_en <= 1'b0;
      // No pulse on the edge that enters stop or wait
      if (state_q != ST_RUN || i_stop_instruction || i_wait_instruction) begin // RULE1 RULE8
        phi_div_q <= 3'd0;
      end else if (clk_tick) begin
        if (phi_div_q >= div_max) begin
          phi_div_q <= 3'd0;
          o_phi_en <= 1'b1; // RULE16
        end else begin
          phi_div_q <= phi_div_q + 3'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // CPU mode register with write lock
  // ----------------------------------------
  assign wr_cm = i_wr && (i_addr == `ADDR_CPUMODE);
  assign lock_hit = `CM_LOCK_MASK >> i_bit_idx;
  assign bit_op_lock = i_bit_op && !lock_hit[0]; // RULE14

  always @(posedge i_core_clk) begin
    if (rst_all) begin
      cpumode_q <= `RST_CPUMODE;
      lock_q <= 1'b0;
      onchip_sel_q <= 1'b1; // RULE11
    end else if (wr_cm) begin
      cpumode_q[7:6] <= i_wdata[7:6]; // RULE15
      cpumode_q[4:2] <= i_wdata[4:2]; // RULE15
      lock_q <= 1'b1; // RULE13 RULE14
      if (!lock_q && !bit_op_lock) begin
        cpumode_q[5] <= i_wdata[5]; // RULE13
        cpumode_q[1:0] <= i_wdata[1:0]; // RULE13
        onchip_sel_q <= 1'b0; // RULE11
      end
    end
  end

  // ----------------------------------------
  // Oscillation stop detection
  // ----------------------------------------
  assign detect_on = osdctl_q[`OSD_ENABLE] && onchip_run && main_run && !onchip_sel_q; // RULE21
  assign loss = detect_on && onchip_tick && (loss_cnt_q == `OSC_LOSS_TICKS);

  always @(posedge i_core_clk) begin
    if (rst_all) begin
      tcsrc_q <= `RST_TCSRC;
      osdctl_q <= 2'b00;
      loss_cnt_q <= 4'h0;
    end else begin
      if (i_wr && i_addr == `ADDR_TCSRC) begin
        tcsrc_q <= i_wdata;
      end
      if (i_wr && i_addr == `ADDR_OSDCTL) begin
        osdctl_q <= i_wdata[1:0];
      end
      if (!detect_on || main_edge) begin
        loss_cnt_q <= 4'h0;
      end else if (onchip_tick && loss_cnt_q != `OSC_LOSS_TICKS) begin
        loss_cnt_q <= loss_cnt_q + 4'h1;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_osc_stop_reset <= 1'b0;
      status_q <= 1'b0; // RULE19
    end else begin
      o_osc_stop_reset <= loss; // RULE18
      if (loss) begin
        status_q <= 1'b1; // RULE19
      end else if (i_wr && i_addr == `ADDR_OSDCTL && !i_wdata[`OSD_ENABLE]) begin
        status_q <= 1'b0; // RULE20
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (rst_all) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ADDR_PRESC1: o_rdata <= presc_q;
        `ADDR_TIMER1: o_rdata <= timer_q;
        `ADDR_TCSRC: o_rdata <= tcsrc_q;
        `ADDR_OSDCTL: o_rdata <= {5'h00, status_q, osdctl_q};
        `ADDR_CPUMODE: o_rdata <= cpumode_q;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // osc_lp_ctrl

// ### osc_lp_ctrl_props.sv
`timescale 1ns/1ps
module osc_lp_ctrl_props (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // Watched events and outputs
  input wire i_stop_instruction,
  input wire i_wait_instruction,
  input wire i_ext_irq_accept,
  input wire i_irq_accept,
  input wire o_main_osc_en,
  input wire o_onchip_osc_en,
  input wire o_phi_en,
  input wire o_phi_held,
  input wire o_on_chip_active,
  input wire o_osc_stop_reset
);
  reg in_wait_q;
  reg in_stop_q;
  wire any_irq = i_irq_accept | i_ext_irq_accept;
  wire stop_main = i_stop_instruction & ~o_on_chip_active;
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      in_wait_q <= 1'b0;
      in_stop_q <= 1'b0;
    end else begin
      in_wait_q <= i_wait_instruction | (in_wait_q & ~any_irq);
      in_stop_q <= stop_main | (in_stop_q & ~i_ext_irq_accept);
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  held_no_clock_a: assert property (o_phi_held |-> !o_phi_en)
    else $error("Clock enable while held");
  stop_osc_off_a: assert property (stop_main |-> ##[1:4] !o_main_osc_en)
    else $error("Oscillator runs after stop");
  stop_held_a: assert property (stop_main |-> ##[1:4] o_phi_held)
    else $error("Clock not held after stop");
  wait_osc_runs_a: assert property (i_wait_instruction && o_main_osc_en |=> o_main_osc_en [*4])
    else $error("Oscillator stopped in wait");
  wait_release_a: assert property (in_wait_q && any_irq |-> ##[0:2] !o_phi_held)
    else $error("Wait release late");
  stop_restart_a: assert property (in_stop_q && i_ext_irq_accept |-> ##[1:3] o_main_osc_en)
    else $error("Oscillator not restarted");
  stop_keep_held_a: assert property (in_stop_q && i_ext_irq_accept |-> o_phi_held [*3])
    else $error("Clock released before underflow");
  boot_onchip_a: assert property ($rose(i_rstn) |-> o_on_chip_active && o_onchip_osc_en)
    else $error("Not on on-chip oscillator after reset");
  detect_ref_a: assert property ($rose(o_osc_stop_reset) |-> $past(o_onchip_osc_en))
    else $error("Loss reset without reference");
  cover property (in_stop_q && i_ext_irq_accept);
  cover property (in_wait_q && i_irq_accept);
  cover property ($rose(o_osc_stop_reset));
endmodule // osc_lp_ctrl_props

bind osc_lp_ctrl osc_lp_ctrl_props osc_lp_ctrl_props_i (.i_core_clk, .i_rstn,
  .i_stop_instruction, .i_wait_instruction, .i_ext_irq_accept, .i_irq_accept, .o_main_osc_en,
  .o_onchip_osc_en, .o_phi_en, .o_phi_held, .o_on_chip_active, .o_osc_stop_reset);

// ### osc_lp_map.vh
// Notes on behaviour
// RULE1: Stop instruction holds clock high, stops main oscillator.
// RULE2: Stop with select bit 0 loads 01/ff.
// RULE3: Stop with select bit 1 keeps timer values.
// RULE4: Prescaler source follows timer count-source setting.
// RULE5: Interrupt restarts oscillator; clock waits for underflow.
// RULE6: Reset exit from stop has no wait.
// RULE7: Software never stops from on-chip oscillator.
// RULE8: Wait instruction holds clock high, oscillator runs.
// RULE9: Wait ends at once on reset or interrupt.
// RULE10: Software enables interrupts before stop or wait.
// RULE11: Starts on on-chip oscillator; bit 5 selects type.
// RULE12: Software uses double speed only with ceramic.
// RULE13: Bits 5, 1, 0 accept one write only.
// RULE14: Bit operation on other bits locks them.
// RULE15: Ratio bits 7:6, main run 4, on-chip 3.
// RULE16: Clock period is 1, 2 or 8 oscillator periods.
// RULE17: Software never stops the selected operating clock.
// RULE18: Oscillator loss raises an internal reset.
// RULE19: Stop status survives own reset, external reset clears.
// RULE20: Writing 0 to detect enable clears status.
// RULE21: Detection needs the on-chip oscillator running.
// RULE22: Software never stops during a conversion.
// RULE23: Prescaler underflow steps timer; its underflow releases clock.
`ifndef OSC_LP_MAP_VH
`define OSC_LP_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_PRESC1 8'h28
`define ADDR_TIMER1 8'h29
`define ADDR_TCSRC 8'h2e
`define ADDR_OSDCTL 8'h38
`define ADDR_CPUMODE 8'h3b

// ----------------------------------------
// Reset values and values loaded on stop
// ----------------------------------------
`define RST_PRESC1 8'hff
`define RST_TIMER1 8'h01
`define RST_TCSRC 8'h00
`define RST_OSDCTL 8'h00
`define RST_CPUMODE 8'h80
`define STOP_PRESC1 8'hff
`define STOP_TIMER1 8'h01

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CM_RATIO_HI 7
`define CM_RATIO_LO 6
`define CM_OSC_SEL 5
`define CM_MAIN_RUN 4
`define CM_ONCHIP_RUN 3
`define CM_LOCK_MASK 8'h23
`define TC_T1_SRC 0
`define OSD_ENABLE 0
`define OSD_STAB_SEL 1
`define OSD_STATUS 2
`define OSD_WMASK 8'h03

// ----------------------------------------
// Division ratio codes
// ----------------------------------------
`define RATIO_DOUBLE 2'b00
`define RATIO_HIGH 2'b01
`define RATIO_MIDDLE 2'b10
`define DIV_HIGH 3'd1
`define DIV_MIDDLE 3'd7

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ONCHIP_DIV 4'd9
`define MAIN_PRE_DIV 4'd15
`define OSC_LOSS_TICKS 4'd8

`endif

// ### oscillation_low_power_control_tb.sv
`timescale 1ns/1ps
`include "osc_lp_map.vh"
module oscillation_low_power_control_tb;
  reg i_core_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_bit_op = 1'b0;
  reg [2:0] i_bit_idx = 3'h0;
  reg i_stop_instruction = 1'b0;
  reg i_wait_instruction = 1'b0;
  reg i_ext_irq_accept = 1'b0;
  reg i_irq_accept = 1'b0;
  reg osc_dead = 1'b0;
  wire i_main_osc_input;
  wire [7:0] o_rdata;
  wire o_main_osc_en, o_onchip_osc_en, o_phi_en, o_phi_held, o_on_chip_active, o_osc_stop_reset;
  integer n_fail = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer d1, d2, m, h, d, n;
  reg [7:0] v;
  always #12.5 i_core_clk = ~i_core_clk;
  osc_lp_ctrl osc_lp_ctrl_i (.i_core_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_bit_op, .i_bit_idx, .i_stop_instruction, .i_wait_instruction, .i_ext_irq_accept,
    .i_irq_accept, .i_main_osc_input, .o_main_osc_en, .o_onchip_osc_en, .o_phi_en,
    .o_phi_held, .o_on_chip_active, .o_osc_stop_reset);
  main_osc_model main_osc_model_i (.i_core_clk, .i_en(o_main_osc_en), .i_dead(osc_dead),
    .o_osc(i_main_osc_input));
  task complete_run; begin
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  task chk(input [7:0] g, input [7:0] e); begin
    check_count = check_count + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  end endtask
  task wr(input [7:0] a, input [7:0] dt, input b, input [2:0] ix); begin
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= dt;
    i_bit_op <= b;
    i_bit_idx <= ix;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_bit_op <= 1'b0;
  end endtask
  task rd(input [7:0] a, output [7:0] r); begin
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 r = o_rdata;
  end endtask
  // Event pulse: 0 stop, 1 wait, 2 external irq, 3 irq
  task ev(input integer k); begin
    @(posedge i_core_clk);
    i_stop_instruction <= (k == 0);
    i_wait_instruction <= (k == 1);
    i_ext_irq_accept <= (k == 2);
    i_irq_accept <= (k == 3);
    @(posedge i_core_clk);
    {i_stop_instruction, i_wait_instruction, i_ext_irq_accept, i_irq_accept} <= 4'h0;
  end endtask
  task settle(input integer c); begin
    repeat (c) @(posedge i_core_clk);
    #1;
  end endtask
  task rst; begin
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (16) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    settle(1);
  end endtask
  task held_time(output integer c); begin
    c = 0;
    while (o_phi_held !== 1'b0 && c < 30000) begin
      settle(1);
      c = c + 1;
    end
  end endtask
  task cnt(input [7:0] mode, output integer c); begin
    wr(`ADDR_CPUMODE, mode, 1'b0, 3'h0);
    settle(20);
    c = 0;
    repeat (240) begin
      settle(1);
      if (o_phi_en === 1'b1) c = c + 1;
    end
  end endtask
  task lose; begin
    wr(`ADDR_CPUMODE, 8'h40, 1'b0, 3'h0);
    wr(`ADDR_OSDCTL, 8'h01, 1'b0, 3'h0);
    settle(10);
    osc_dead <= 1'b1;
    n = 0;
    while (o_osc_stop_reset !== 1'b1 && n < 3000) begin settle(1); n = n + 1; end
    chk(o_osc_stop_reset, 8'h01);
    osc_dead <= 1'b0;
    while (o_osc_stop_reset !== 1'b0 && n < 6000) begin settle(1); n = n + 1; end
    rd(`ADDR_OSDCTL, v);
    chk(v & 8'h04, 8'h04);
  end endtask
  task t_regs; begin
    rst;
    chk(o_on_chip_active, 8'h01);
    rd(`ADDR_CPUMODE, v);
    chk(v, `RST_CPUMODE);
    rd(`ADDR_OSDCTL, v);
    chk(v, `RST_OSDCTL);
    wr(`ADDR_CPUMODE, 8'h40, 1'b0, 3'h0);
    rd(`ADDR_CPUMODE, v);
    chk(v, 8'h40);
    wr(`ADDR_CPUMODE, 8'ha3, 1'b0, 3'h0);
    rd(`ADDR_CPUMODE, v);
    chk(v, 8'h80);
    $display("test regs done");
  end endtask
  task t_bitop; begin
    rst;
    wr(`ADDR_CPUMODE, 8'hc0, 1'b1, 3'h6);
    wr(`ADDR_CPUMODE, 8'h23, 1'b0, 3'h0);
    rd(`ADDR_CPUMODE, v);
    chk(v, 8'h00);
    $display("test bit lock done");
  end endtask
  task t_ratio; begin
    cnt(8'h80, m);
    cnt(8'h40, h);
    cnt(8'h00, d);
    chk(m > 0 && h >= 4 * m - 4 && h <= 4 * m + 4, 8'h01);
    chk(d >= 2 * h - 4 && d <= 2 * h + 4, 8'h01);
    $display("test ratio done");
  end endtask
  task t_wait; begin
    v = o_main_osc_en;
    ev(1);
    settle(3);
    chk(o_phi_held, 8'h01);
    chk(o_main_osc_en, v);
    ev(3);
    settle(1);
    chk(o_phi_held, 8'h00);
    $display("test wait done");
  end endtask
  task t_stop; begin
    rst;
    wr(`ADDR_CPUMODE, 8'h48, 1'b0, 3'h0);
    n = 0;
    while (o_on_chip_active !== 1'b0 && n < 500) begin settle(1); n = n + 1; end
    chk(o_on_chip_active, 8'h00);
    ev(0);
    settle(4);
    chk({o_phi_held, o_main_osc_en}, 8'h02);
    rd(`ADDR_TIMER1, v);
    chk(v, `STOP_TIMER1);
    rd(`ADDR_PRESC1, v);
    chk(v, `STOP_PRESC1);
    ev(2);
    settle(1);
    chk(o_phi_held, 8'h01);
    held_time(d1);
    chk(d1 > 16000 && d1 < 17000, 8'h01);
    wr(`ADDR_OSDCTL, 8'h02, 1'b0, 3'h0);
    wr(`ADDR_TIMER1, 8'h00, 1'b0, 3'h0);
    wr(`ADDR_PRESC1, 8'h03, 1'b0, 3'h0);
    ev(0);
    settle(4);
    ev(2);
    held_time(d2);
    chk(d2 < 300 && d2 < d1, 8'h01);
    ev(0);
    settle(4);
    rst;
    chk(o_phi_held, 8'h00);
    $display("test stop done");
  end endtask
  task t_loss; begin
    lose;
    rst;
    rd(`ADDR_OSDCTL, v);
    chk(v & 8'h04, 8'h00);
    lose;
    wr(`ADDR_OSDCTL, 8'h00, 1'b0, 3'h0);
    rd(`ADDR_OSDCTL, v);
    chk(v & 8'h04, 8'h00);
    $display("test loss done");
  end endtask
  initial begin
    t_regs;
    t_bitop;
    t_ratio;
    t_wait;
    t_stop;
    t_loss;
    complete_run;
  end
endmodule // oscillation_low_power_control_tb
